// ===== src/swdt_pkg.sv
// Package of constants for the system watchdog timer
package swdt_pkg;
    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam logic [11:0] SWDT_CTRL_OFF   = 12'h000;
    localparam logic [11:0] SWDT_CLEAR_OFF  = 12'h004;
    localparam logic [11:0] SWDT_COUNT_OFF  = 12'h008;
    localparam logic [11:0] SWDT_STAT_OFF   = 12'h00C;
    localparam logic [11:0] SWDT_IRQ_EN_OFF = 12'h010;
    localparam logic [11:0] SWDT_IRQ_CLR_OFF = 12'h014;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int CTRL_ENABLE_BIT  = 0;
    localparam int CTRL_AUTOCLR_BIT = 1;
    localparam int CTRL_TSEL_LSB    = 4;
    localparam int STAT_TIMEOUT_BIT = 0;
    localparam int STAT_CLEARED_BIT = 1;
    localparam int STAT_CAUSE_BIT   = 2;
    localparam int STAT_RUNNING_BIT = 3;
    localparam int IRQ_TIMEOUT_BIT  = 0;
    localparam int IRQ_CLEARED_BIT  = 1;

    // ****************************************************************
    // Values and timing
    // ****************************************************************
    localparam logic [1:0]  CLEAR_PATTERN    = 2'h1;
    localparam logic [1:0]  TSEL_RESET       = 2'h0;
    localparam logic [1:0]  IRQ_RESET        = 2'h0;
    localparam logic [31:0] SWDT_SLVERR_DATA = 32'h00000000;
    localparam int          CLK_HZ           = 100_000_000;
    localparam int          TICK_HZ          = 1;
    localparam int          TICK_DIV_DEF     = CLK_HZ / TICK_HZ;
    localparam int          TIMEOUT_MIN_S    = 2;
    localparam int          TIMEOUT_MAX_S    = 128;
    localparam int          CNT_W            = 8;

    typedef enum logic [1:0] {
        SWDT_ST_OFF     = 2'b00,
        SWDT_ST_RUN     = 2'b01,
        SWDT_ST_EXPIRED = 2'b11
    } swdt_state_t;
endpackage

// ===== src/swdt_tick.sv
// Tick divider that stands in for the internal oscillator
`timescale 1ns/1ps
module swdt_tick
    import swdt_pkg::*;
#(
    parameter int DIV = TICK_DIV_DEF
) (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_run,
    output logic      o_tick
);
    typedef struct packed {
        logic [31:0] cnt;
        logic        tick;
    } swdt_tick_st_t;

    swdt_tick_st_t st_reg;
    swdt_tick_st_t st_next;

    always_comb begin
        st_next      = st_reg;
        st_next.tick = 1'b0;
        if (!i_run) begin
            st_next.cnt = 32'h00000000;
        end else if (st_reg.cnt >= 32'(DIV - 1)) begin
            st_next.cnt  = 32'h00000000;
            st_next.tick = 1'b1;
        end else begin
            st_next.cnt = st_reg.cnt + 32'h00000001;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_tick = st_reg.tick;
endmodule

// ===== src/swdt_top.sv
// System watchdog timer with APB registers and interrupt
//
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module swdt_top
    import swdt_pkg::*;
#(
    parameter int         TICK_DIV = TICK_DIV_DEF,
    parameter logic [7:0] TOUT_S0  = 8'h02,
    parameter logic [7:0] TOUT_S1  = 8'h10,
    parameter logic [7:0] TOUT_S2  = 8'h40,
    parameter logic [7:0] TOUT_S3  = 8'h80
) (
    input  wire logic        I_CLK_SYS,
    input  wire logic        I_RST_N,
    input  wire logic        i_PSEL,
    input  wire logic        i_PENABLE,
    input  wire logic        i_PWRITE,
    input  wire logic [11:0] i_PADDR,
    input  wire logic [31:0] i_PWDATA,
    output logic [31:0]      o_PRDATA,
    output logic             o_PREADY,
    output logic             o_PSLVERR,
    input  wire logic        i_OTP_DEFAULT_ENABLE,
    input  wire logic        i_SEQUENCER_SLOT_ONE_EN,
    input  wire logic        i_SEQUENCER_SLOT_TWO_EN,
    input  wire logic        i_BIDIR_RESET_IO_IN,
    input  wire logic        i_CAUSE_FLAG_CLR,
    output logic             o_BIDIR_RESET_IO_OUT,
    output logic             o_BIDIR_RESET_IO_OE,
    output logic             o_GLOBAL_SHUTDOWN,
    output logic             o_WATCHDOG_CAUSE_FLAG,
    output logic             o_IRQ
);
    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        swdt_state_t       fsm;
        logic              enable;
        logic              autoclr;
        logic [1:0]        tsel;
        logic [CNT_W-1:0]  count;
        logic [1:0]        irq_stat;
        logic [1:0]        irq_en;
        logic              cause;
        logic              shutdown;
        logic              rst_drive;
        logic              irq;
        logic              boot;
        logic [31:0]       prdata;
        logic              pready;
        logic              pslverr;
    } swdt_st_t;

    swdt_st_t st_reg;
    swdt_st_t st_next;
    logic     tick;

    // Period of a timeout code in ticks
    function automatic logic [CNT_W-1:0] swdt_limit(input logic [1:0] code);
        case (code)
            2'h0:    swdt_limit = TOUT_S0;
            2'h1:    swdt_limit = TOUT_S1;
            2'h2:    swdt_limit = TOUT_S2;
            default: swdt_limit = TOUT_S3;
        endcase
    endfunction

    swdt_tick #(
        .DIV (TICK_DIV)
    ) u_tick (
        .i_clk   (I_CLK_SYS),
        .i_rst_n (I_RST_N),
        .i_run   (st_reg.fsm == SWDT_ST_RUN),
        .o_tick  (tick)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    logic            wr;
    logic            rd;
    logic            kick;
    logic            host_idle;
    logic [1:0]      ev;
    logic [CNT_W-1:0] limit;

    always_comb begin
        st_next         = st_reg;
        wr              = i_PSEL && i_PENABLE && i_PWRITE && !st_reg.pready;
        rd              = i_PSEL && i_PENABLE && !i_PWRITE && !st_reg.pready;
        kick            = 1'b0;
        ev              = 2'b00;
        limit           = swdt_limit(st_reg.tsel);
        st_next.pready  = 1'b0;
        st_next.pslverr = 1'b0;
        st_next.boot    = 1'b0;

        if (st_reg.boot) begin
            st_next.enable = i_OTP_DEFAULT_ENABLE;
        end

        if (wr) begin
            st_next.pready = 1'b1;
            if (i_PADDR == SWDT_CTRL_OFF) begin
                st_next.enable  = i_PWDATA[CTRL_ENABLE_BIT];
                st_next.autoclr = i_PWDATA[CTRL_AUTOCLR_BIT];
                st_next.tsel    = i_PWDATA[CTRL_TSEL_LSB +: 2];
            end else if (i_PADDR == SWDT_CLEAR_OFF) begin
                kick = (i_PWDATA[1:0] == CLEAR_PATTERN);
            end else if (i_PADDR == SWDT_IRQ_EN_OFF) begin
                st_next.irq_en = i_PWDATA[1:0];
            end else if (i_PADDR == SWDT_IRQ_CLR_OFF) begin
                st_next.irq_stat = st_reg.irq_stat & ~i_PWDATA[1:0];
            end else if (i_PADDR != SWDT_COUNT_OFF && i_PADDR != SWDT_STAT_OFF) begin
                // Error replies always carry the fixed error word
                st_next.prdata  = SWDT_SLVERR_DATA;
                st_next.pslverr = 1'b1;
            end
        end else if (rd) begin
            st_next.pready = 1'b1;
            st_next.prdata = 32'h00000000;
            if (i_PADDR == SWDT_CTRL_OFF) begin
                st_next.prdata[CTRL_ENABLE_BIT]       = st_reg.enable;
                st_next.prdata[CTRL_AUTOCLR_BIT]      = st_reg.autoclr;
                st_next.prdata[CTRL_TSEL_LSB +: 2]    = st_reg.tsel;
            end else if (i_PADDR == SWDT_CLEAR_OFF) begin
                st_next.prdata = 32'h00000000;
            end else if (i_PADDR == SWDT_COUNT_OFF) begin
                st_next.prdata[CNT_W-1:0] = st_reg.count;
            end else if (i_PADDR == SWDT_STAT_OFF) begin
                st_next.prdata[STAT_TIMEOUT_BIT] = st_reg.irq_stat[IRQ_TIMEOUT_BIT];
                st_next.prdata[STAT_CLEARED_BIT] = st_reg.irq_stat[IRQ_CLEARED_BIT];
                st_next.prdata[STAT_CAUSE_BIT]   = st_reg.cause;
                st_next.prdata[STAT_RUNNING_BIT] = (st_reg.fsm == SWDT_ST_RUN);
            end else if (i_PADDR == SWDT_IRQ_EN_OFF) begin
                st_next.prdata[1:0] = st_reg.irq_en;
            end else if (i_PADDR == SWDT_IRQ_CLR_OFF) begin
                st_next.prdata = 32'h00000000;
            end else begin
                st_next.prdata  = SWDT_SLVERR_DATA;
                st_next.pslverr = 1'b1;
            end
        end

        // Asleep when slot one is off; off when both slots are off
        host_idle = !i_SEQUENCER_SLOT_ONE_EN
                  || (!i_SEQUENCER_SLOT_ONE_EN && !i_SEQUENCER_SLOT_TWO_EN);
        if (st_reg.autoclr && host_idle) begin
            kick = 1'b1;
        end

        case (st_reg.fsm)
            SWDT_ST_OFF: begin
                st_next.count = '0;
                if (st_reg.enable) begin
                    st_next.fsm = SWDT_ST_RUN;
                end
            end
            SWDT_ST_RUN: begin
                if (!st_reg.enable) begin
                    st_next.fsm   = SWDT_ST_OFF;
                    st_next.count = '0;
                end else if (kick) begin
                    st_next.count = '0;
                    ev[IRQ_CLEARED_BIT] = 1'b1;
                end else if (tick) begin
                    if (st_reg.count + 1'b1 >= limit) begin
                        st_next.fsm       = SWDT_ST_EXPIRED;
                        st_next.rst_drive = 1'b1;
                        st_next.shutdown  = 1'b1;
                        st_next.cause     = 1'b1;
                        ev[IRQ_TIMEOUT_BIT] = 1'b1;
                    end
                    st_next.count = CNT_W'(st_reg.count + 1'b1);
                end
            end
            SWDT_ST_EXPIRED: begin
                // Held until the device is reset by the power controller
                st_next.rst_drive = 1'b1;
                st_next.shutdown  = 1'b1;
            end
            default: begin
                st_next.fsm = SWDT_ST_OFF;
            end
        endcase

        if (i_CAUSE_FLAG_CLR && !ev[IRQ_TIMEOUT_BIT]) begin
            st_next.cause = 1'b0;
        end
        // Set wins over a simultaneous clear
        st_next.irq_stat = st_next.irq_stat | ev;
        st_next.irq      = |(st_next.irq_stat & st_next.irq_en);
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            st_reg          <= '0;
            st_reg.fsm      <= SWDT_ST_OFF;
            st_reg.tsel     <= TSEL_RESET;
            st_reg.irq_en   <= IRQ_RESET;
            st_reg.boot     <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_PRDATA              = st_reg.prdata;
    assign o_PREADY              = st_reg.pready;
    assign o_PSLVERR             = st_reg.pslverr;
    assign o_BIDIR_RESET_IO_OUT  = 1'b0;
    assign o_BIDIR_RESET_IO_OE   = st_reg.rst_drive;
    assign o_GLOBAL_SHUTDOWN     = st_reg.shutdown;
    assign o_WATCHDOG_CAUSE_FLAG = st_reg.cause;
    assign o_IRQ                 = st_reg.irq;
endmodule

// ===== test/swdt_checker.sv
// Port checker for the system watchdog timer
`timescale 1ns/1ps
module swdt_checker (
    input wire logic        I_CLK_SYS,
    input wire logic        I_RST_N,
    input wire logic        i_PSEL,
    input wire logic        i_PENABLE,
    input wire logic [31:0] o_PRDATA,
    input wire logic        o_PREADY,
    input wire logic        o_PSLVERR,
    input wire logic        o_BIDIR_RESET_IO_OUT,
    input wire logic        o_BIDIR_RESET_IO_OE,
    input wire logic        o_GLOBAL_SHUTDOWN,
    input wire logic        o_WATCHDOG_CAUSE_FLAG,
    input wire logic        o_IRQ
);
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RST_N);
    a_ready_pulse: assert property (o_PREADY |=> !o_PREADY) else $error("ready held too long");
    a_ready_wait: assert property (i_PSEL && i_PENABLE && !o_PREADY |=> o_PREADY) else $error("ready late");
    a_idle_quiet: assert property (!i_PSEL |=> !o_PREADY) else $error("ready without select");
    a_err_zero: assert property (o_PSLVERR |-> o_PREADY && o_PRDATA == 32'h00000000) else $error("bad error reply");
    a_shdn_sticky: assert property (o_GLOBAL_SHUTDOWN |=> o_GLOBAL_SHUTDOWN) else $error("shutdown dropped");
    a_pin_follows: assert property (o_BIDIR_RESET_IO_OE == o_GLOBAL_SHUTDOWN) else $error("reset pin mismatch");
    a_pin_low: assert property (!o_BIDIR_RESET_IO_OUT) else $error("reset pin drives high");
    a_cause_set: assert property ($rose(o_GLOBAL_SHUTDOWN) |-> o_WATCHDOG_CAUSE_FLAG) else $error("cause missing");
    c_shdn: cover property ($rose(o_GLOBAL_SHUTDOWN));
    c_err: cover property (o_PSLVERR);
    c_irq: cover property ($rose(o_IRQ));
endmodule
bind swdt_top swdt_checker u_chk (.I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N), .i_PSEL(i_PSEL),
    .i_PENABLE(i_PENABLE), .o_PRDATA(o_PRDATA), .o_PREADY(o_PREADY), .o_PSLVERR(o_PSLVERR),
    .o_BIDIR_RESET_IO_OUT(o_BIDIR_RESET_IO_OUT), .o_BIDIR_RESET_IO_OE(o_BIDIR_RESET_IO_OE),
    .o_GLOBAL_SHUTDOWN(o_GLOBAL_SHUTDOWN), .o_WATCHDOG_CAUSE_FLAG(o_WATCHDOG_CAUSE_FLAG), .o_IRQ(o_IRQ));

// ===== test/swdt_top_test.sv
// Self-checking testbench for the system watchdog timer
`timescale 1ns/1ps
module swdt_top_test;
    import swdt_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, rv, c1;
    logic        otp = 1'b0, s1 = 1'b1, s2 = 1'b1, ev, cclr = 1'b0;
    logic        pready, pslverr, io_out, io_oe, shdn, cause, irq;
    int          miscompares = 0, checks_done = 0, cyc = 0;
    swdt_top #(.TICK_DIV(4)) uut (.I_CLK_SYS(clk), .I_RST_N(rst_n), .i_PSEL(psel), .i_PENABLE(pen),
        .i_PWRITE(pwr), .i_PADDR(paddr), .i_PWDATA(pwdata), .o_PRDATA(prdata), .o_PREADY(pready),
        .o_PSLVERR(pslverr), .i_OTP_DEFAULT_ENABLE(otp), .i_SEQUENCER_SLOT_ONE_EN(s1),
        .i_SEQUENCER_SLOT_TWO_EN(s2), .i_BIDIR_RESET_IO_IN(1'b1), .i_CAUSE_FLAG_CLR(cclr),
        .o_BIDIR_RESET_IO_OUT(io_out), .o_BIDIR_RESET_IO_OE(io_oe), .o_GLOBAL_SHUTDOWN(shdn),
        .o_WATCHDOG_CAUSE_FLAG(cause), .o_IRQ(irq));
    initial begin
        forever #5 clk = ~clk;
    end
    task finish_test;
        if (miscompares == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            finish_test;
        end
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0; pen <= 1'b0;
        if (n >= 50) chk("pready", 32'h1, 32'h0);
    endtask
    task run(input int n);
        repeat (n) @(posedge clk);
    endtask
    task do_reset(input logic o);
        rst_n <= 1'b0; otp <= o;
        run(16);
        rst_n <= 1'b1;
    endtask
    task t_default_on;
        do_reset(1'b1);
        apb(1'b0, SWDT_CTRL_OFF, 32'h0);
        chk("enable default", 32'h1, 32'(rv[CTRL_ENABLE_BIT]));
        run(30);
        chk("shutdown", 32'h1, 32'(shdn));
        chk("reset pin", 32'h1, 32'(io_oe));
        chk("cause", 32'h1, 32'(cause));
        apb(1'b0, SWDT_STAT_OFF, 32'h0);
        chk("status", (32'h1 << STAT_TIMEOUT_BIT) | (32'h1 << STAT_CAUSE_BIT), rv);
        cclr <= 1'b1;
        run(2);
        chk("cause cleared", 32'h0, 32'(cause));
        cclr <= 1'b0;
        chk("shutdown held", 32'h1, 32'(shdn));
    endtask
    task t_disabled;
        do_reset(1'b0);
        apb(1'b0, SWDT_CTRL_OFF, 32'h0);
        chk("enable default", 32'h0, 32'(rv[CTRL_ENABLE_BIT]));
        apb(1'b0, 12'h100, 32'h0);
        chk("unmapped err", 32'h1, 32'(ev));
        chk("unmapped data", 32'h0, rv);
        run(300);
        chk("shutdown off", 32'h0, 32'(shdn));
    endtask
    task t_codes;
        int lim[4] = '{2, 16, 64, 128};
        for (int k = 0; k < 4; k++) begin
            do_reset(1'b0);
            apb(1'b1, SWDT_CTRL_OFF, 32'(k) << CTRL_TSEL_LSB | 32'h1);
            run((lim[k] - 1) * 4);
            chk("early shutdown", 32'h0, 32'(shdn));
            run(14);
            chk("timeout shutdown", 32'h1, 32'(shdn));
        end
    endtask
    task t_clear;
        do_reset(1'b0);
        apb(1'b1, SWDT_CTRL_OFF, 32'h1 << CTRL_TSEL_LSB | 32'h1);
        apb(1'b1, SWDT_CLEAR_OFF, 32'h1);
        run(2);
        chk("irq masked", 32'h0, 32'(irq));
        apb(1'b1, SWDT_IRQ_EN_OFF, 32'h2);
        run(2);
        chk("irq set", 32'h1, 32'(irq));
        apb(1'b1, SWDT_IRQ_CLR_OFF, 32'h2);
        run(2);
        chk("irq cleared", 32'h0, 32'(irq));
        for (int i = 0; i < 6; i++) begin
            run(30);
            apb(1'b1, SWDT_CLEAR_OFF, 32'h1);
        end
        chk("kept alive", 32'h0, 32'(shdn));
        apb(1'b0, SWDT_COUNT_OFF, 32'h0);
        c1 = rv;
        run(8);
        apb(1'b1, SWDT_CLEAR_OFF, 32'h2);
        apb(1'b0, SWDT_COUNT_OFF, 32'h0);
        chk("count kept", 32'h1, 32'(rv > c1));
        apb(1'b0, SWDT_CLEAR_OFF, 32'h0);
        chk("clear field", 32'h0, rv);
        apb(1'b1, SWDT_CLEAR_OFF, 32'h1);
        apb(1'b0, SWDT_COUNT_OFF, 32'h0);
        chk("count restart", 32'h1, 32'(rv < 2));
        run(40);
        chk("no timeout", 32'h0, 32'(shdn));
        run(60);
        chk("timeout", 32'h1, 32'(shdn));
    endtask
    task t_auto;
        do_reset(1'b0);
        s1 <= 1'b0; s2 <= 1'b1;
        apb(1'b1, SWDT_CTRL_OFF, 32'h3);
        run(100);
        chk("sleep autoclear", 32'h0, 32'(shdn));
        s2 <= 1'b0;
        run(100);
        chk("off autoclear", 32'h0, 32'(shdn));
        s1 <= 1'b1; s2 <= 1'b1;
        run(30);
        chk("awake timeout", 32'h1, 32'(shdn));
    endtask
    initial begin
        t_default_on;
        t_disabled;
        t_codes;
        t_clear;
        t_auto;
        finish_test;
    end
endmodule
